/* File: rtl/cbu_pkg.sv */
// Package with constants, opcode enumeration and state codes for the branch unit
package cbu_pkg;
  localparam int CBU_PC_W = 16;
  localparam int CBU_OFS_W = 7;
  localparam int CBU_SREG_W = 8;
  // Status register bit positions
  localparam int CBU_BIT_C = 0;
  localparam int CBU_BIT_Z = 1;
  localparam int CBU_BIT_N = 2;
  localparam int CBU_BIT_V = 3;
  localparam int CBU_BIT_S = 4;
  localparam int CBU_BIT_H = 5;
  localparam int CBU_BIT_T = 6;
  localparam int CBU_BIT_I = 7;
  // Cycle counts of a branch
  localparam int CBU_CYC_NOT_TAKEN = 1;
  localparam int CBU_CYC_TAKEN = 2;
  localparam logic [CBU_PC_W-1:0] CBU_PC_RESET = 16'h0000;
  localparam logic [CBU_PC_W-1:0] CBU_PC_ONE = 16'h0001;
  localparam int CBU_NUM_COND = 15;

  typedef enum logic [3:0] {
    CBU_BRANCH_ON_EQUAL = 4'h0,
    CBU_BRANCH_ON_NOT_EQUAL = 4'h1,
    CBU_BRANCH_ON_CARRY_SET = 4'h2,
    CBU_BRANCH_ON_CARRY_CLEAR = 4'h3,
    CBU_BRANCH_ON_SAME_OR_HIGHER = 4'h4,
    CBU_BRANCH_ON_LOWER = 4'h5,
    CBU_BRANCH_ON_MINUS = 4'h6,
    CBU_BRANCH_ON_PLUS = 4'h7,
    CBU_BRANCH_ON_SIGNED_GE = 4'h8,
    CBU_BRANCH_ON_SIGNED_LT = 4'h9,
    CBU_BRANCH_ON_HALF_CARRY_SET = 4'hA,
    CBU_BRANCH_ON_HALF_CARRY_CLEAR = 4'hB,
    CBU_BRANCH_ON_TRANSFER_SET = 4'hC,
    CBU_BRANCH_ON_TRANSFER_CLEAR = 4'hD,
    CBU_BRANCH_ON_OVERFLOW_SET = 4'hE
  } cbu_op_e;

  typedef enum logic [1:0] {
    CBU_IDLE = 2'b01,
    CBU_SECOND = 2'b10
  } cbu_state_e;
endpackage : cbu_pkg

/* File: rtl/cbu_cond_eval.sv */
// Combinational condition evaluator over the status flags
`timescale 1ns/1ns
module cbu_cond_eval
  import cbu_pkg::*;
(
  input wire logic [3:0] opSel,
  input wire logic [CBU_SREG_W-1:0] flags,
  output logic condTrue,
  output logic opLegal
);
  logic fz;
  logic fc;
  logic fn;
  logic fv;
  logic fh;
  logic ft;

  // Flag taps
  assign fz = flags[CBU_BIT_Z];
  assign fc = flags[CBU_BIT_C];
  assign fn = flags[CBU_BIT_N];
  assign fv = flags[CBU_BIT_V];
  assign fh = flags[CBU_BIT_H];
  assign ft = flags[CBU_BIT_T];

  // One condition per opcode; codes above the list are not branches
  always_comb begin
    condTrue = 1'b0;
    opLegal = 1'b1;
    unique case (opSel)
      CBU_BRANCH_ON_EQUAL: condTrue = fz;
      CBU_BRANCH_ON_NOT_EQUAL: condTrue = ~fz;
      CBU_BRANCH_ON_CARRY_SET: condTrue = fc;
      CBU_BRANCH_ON_CARRY_CLEAR: condTrue = ~fc;
      CBU_BRANCH_ON_SAME_OR_HIGHER: condTrue = ~fc;
      CBU_BRANCH_ON_LOWER: condTrue = fc;
      CBU_BRANCH_ON_MINUS: condTrue = fn;
      CBU_BRANCH_ON_PLUS: condTrue = ~fn;
      CBU_BRANCH_ON_SIGNED_GE: condTrue = ~(fn ^ fv);
      CBU_BRANCH_ON_SIGNED_LT: condTrue = fn ^ fv;
      CBU_BRANCH_ON_HALF_CARRY_SET: condTrue = fh;
      CBU_BRANCH_ON_HALF_CARRY_CLEAR: condTrue = ~fh;
      CBU_BRANCH_ON_TRANSFER_SET: condTrue = ft;
      CBU_BRANCH_ON_TRANSFER_CLEAR: condTrue = ~ft;
      CBU_BRANCH_ON_OVERFLOW_SET: condTrue = fv;
      default: opLegal = 1'b0;
    endcase
  end
endmodule : cbu_cond_eval

/* File: rtl/cbu_branch_unit.sv */
// Conditional relative branch unit: condition test and program-counter update
`timescale 1ns/1ns
module cbu_branch_unit
  import cbu_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic issueValid,
  input wire logic [3:0] issueOp,
  input wire logic [CBU_OFS_W-1:0] issueOffset,
  input wire logic [CBU_SREG_W-1:0] statusIn,
  output logic issueReady,
  output logic [CBU_PC_W-1:0] progCounter,
  output logic [CBU_SREG_W-1:0] statusOut,
  output logic branchTaken,
  output logic branchDone,
  output logic badOpcode
);
  cbu_state_e state;
  cbu_state_e next_state;
  logic [CBU_PC_W-1:0] next_progCounter;
  logic [CBU_PC_W-1:0] targetPc;
  logic [CBU_PC_W-1:0] next_targetPc;
  logic [CBU_SREG_W-1:0] next_statusOut;
  logic next_issueReady;
  logic next_branchTaken;
  logic next_branchDone;
  logic next_badOpcode;
  logic condTrue;
  logic opLegal;
  logic [CBU_PC_W-1:0] offsetExt;
  logic [CBU_PC_W-1:0] takenPc;
  logic accept;

  // Flag test lives in its own leaf so the decode can be reused by the fetch path
  cbu_cond_eval condUnit (
    .opSel(issueOp),
    .flags(statusIn),
    .condTrue(condTrue),
    .opLegal(opLegal)
  );

  // Sign-extend the word offset and form the taken target
  assign offsetExt = {{(CBU_PC_W-CBU_OFS_W){issueOffset[CBU_OFS_W-1]}}, issueOffset};
  assign takenPc = progCounter + offsetExt + CBU_PC_ONE;
  assign accept = issueValid && issueReady && (state == CBU_IDLE);

  // Next-state logic; a taken branch spends a second cycle before the new PC shows
  always_comb begin
    next_state = state;
    next_progCounter = progCounter;
    next_targetPc = targetPc;
    next_statusOut = statusIn;
    next_issueReady = issueReady;
    next_branchTaken = 1'b0;
    next_branchDone = 1'b0;
    next_badOpcode = 1'b0;
    unique case (state)
      CBU_IDLE: begin
        next_issueReady = 1'b1;
        if (accept) begin
          if (!opLegal) begin
            // Unknown code: step past it like a non-branch
            next_badOpcode = 1'b1;
            next_progCounter = progCounter + CBU_PC_ONE;
            next_branchDone = 1'b1;
          end else if (condTrue) begin
            next_targetPc = takenPc;
            next_state = CBU_SECOND;
            next_issueReady = 1'b0;
          end else begin
            next_progCounter = progCounter + CBU_PC_ONE;
            next_branchDone = 1'b1;
          end
        end
      end
      CBU_SECOND: begin
        next_progCounter = targetPc;
        next_branchTaken = 1'b1;
        next_branchDone = 1'b1;
        next_issueReady = 1'b1;
        next_state = CBU_IDLE;
      end
      default: begin
        next_state = CBU_IDLE;
        next_issueReady = 1'b1;
      end
    endcase
  end

  // Registers; clock enable low freezes everything, but a synchronous reset still clears them
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= CBU_IDLE;
      progCounter <= CBU_PC_RESET;
      targetPc <= CBU_PC_RESET;
      statusOut <= '0;
      issueReady <= 1'b0;
      branchTaken <= 1'b0;
      branchDone <= 1'b0;
      badOpcode <= 1'b0;
    end else if (clkEn) begin
      state <= next_state;
      progCounter <= next_progCounter;
      targetPc <= next_targetPc;
      statusOut <= next_statusOut;
      issueReady <= next_issueReady;
      branchTaken <= next_branchTaken;
      branchDone <= next_branchDone;
      badOpcode <= next_badOpcode;
    end
  end

  // Assertion helpers; a taken branch is an accept, then its second cycle
  sequence acceptTaken_s;
    clkEn && accept && opLegal && condTrue;
  endsequence

  sequence secondCycle_s;
    clkEn && state == CBU_SECOND;
  endsequence

  // A frozen cycle in between drops the attempt rather than stretching it
  property takenTarget_p;
    logic [CBU_PC_W-1:0] t;
    @(posedge clock) disable iff (rst)
      (acceptTaken_s, t = takenPc) ##1 secondCycle_s |=> progCounter == t;
  endproperty

  eq_cond_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && issueOp == CBU_BRANCH_ON_EQUAL |=> branchDone != !statusIn[CBU_BIT_Z] || 1'b1 ? 
      ($past(statusIn[CBU_BIT_Z]) ? state == CBU_SECOND : branchDone) : 1'b1)
    else $error("equal branch mismatch with zero flag");

  // Condition checks, one or two per branch code
  ne_cond_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && issueOp == CBU_BRANCH_ON_NOT_EQUAL && statusIn[CBU_BIT_Z]
    |=> branchDone && !branchTaken)
    else $error("not-equal branch taken with zero set");

  ne_taken_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && issueOp == CBU_BRANCH_ON_NOT_EQUAL && !statusIn[CBU_BIT_Z]
    |=> state == CBU_SECOND)
    else $error("not-equal branch not taken with zero clear");

  carry_cond_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && issueOp == CBU_BRANCH_ON_CARRY_SET && !statusIn[CBU_BIT_C]
    |=> state == CBU_IDLE)
    else $error("carry-set branch taken with carry clear");

  carry_set_taken_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && issueOp == CBU_BRANCH_ON_CARRY_SET && statusIn[CBU_BIT_C]
    |=> state == CBU_SECOND)
    else $error("carry-set branch not taken with carry set");

  carry_clear_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && issueOp == CBU_BRANCH_ON_CARRY_CLEAR
    |=> (state == CBU_SECOND) == !$past(statusIn[CBU_BIT_C]))
    else $error("carry-clear branch disagrees with carry flag");

  unsigned_cond_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && issueOp == CBU_BRANCH_ON_SAME_OR_HIGHER && !statusIn[CBU_BIT_C]
    |=> state == CBU_SECOND)
    else $error("same-or-higher branch not taken with carry clear");

  higher_skip_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && issueOp == CBU_BRANCH_ON_SAME_OR_HIGHER && statusIn[CBU_BIT_C]
    |=> state == CBU_IDLE && branchDone)
    else $error("same-or-higher branch taken with carry set");

  lower_cond_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && issueOp == CBU_BRANCH_ON_LOWER
    |=> (state == CBU_SECOND) == $past(statusIn[CBU_BIT_C]))
    else $error("lower branch disagrees with carry flag");

  minus_cond_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && issueOp == CBU_BRANCH_ON_MINUS
    |=> (state == CBU_SECOND) == $past(statusIn[CBU_BIT_N]))
    else $error("minus branch disagrees with negative flag");

  plus_cond_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && issueOp == CBU_BRANCH_ON_PLUS
    |=> (state == CBU_SECOND) == !$past(statusIn[CBU_BIT_N]))
    else $error("plus branch disagrees with negative flag");

  signed_ge_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && issueOp == CBU_BRANCH_ON_SIGNED_GE
    |=> (state == CBU_SECOND) == !($past(statusIn[CBU_BIT_N]) ^ $past(statusIn[CBU_BIT_V])))
    else $error("signed ge branch disagrees with n xor v");

  signed_lt_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && issueOp == CBU_BRANCH_ON_SIGNED_LT
    |=> (state == CBU_SECOND) == ($past(statusIn[CBU_BIT_N]) ^ $past(statusIn[CBU_BIT_V])))
    else $error("signed lt branch disagrees with n xor v");

  half_cond_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && issueOp == CBU_BRANCH_ON_HALF_CARRY_CLEAR
    |=> (state == CBU_SECOND) == !$past(statusIn[CBU_BIT_H]))
    else $error("half-carry clear branch disagrees with flag");

  half_set_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && issueOp == CBU_BRANCH_ON_HALF_CARRY_SET
    |=> (state == CBU_SECOND) == $past(statusIn[CBU_BIT_H]))
    else $error("half-carry set branch disagrees with flag");

  transfer_cond_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && issueOp == CBU_BRANCH_ON_TRANSFER_SET
    |=> (state == CBU_SECOND) == $past(statusIn[CBU_BIT_T]))
    else $error("transfer set branch disagrees with flag");

  transfer_clear_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && issueOp == CBU_BRANCH_ON_TRANSFER_CLEAR
    |=> (state == CBU_SECOND) == !$past(statusIn[CBU_BIT_T]))
    else $error("transfer clear branch disagrees with flag");

  overflow_cond_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && issueOp == CBU_BRANCH_ON_OVERFLOW_SET
    |=> (state == CBU_SECOND) == $past(statusIn[CBU_BIT_V]))
    else $error("overflow branch disagrees with flag");

  // Target, timing and handshake checks
  taken_target_a: assert property (takenTarget_p)
    else $error("taken branch target is not pc plus offset plus one");

  flags_kept_a: assert property (@(posedge clock) disable iff (rst)
    !rst && clkEn
    |=> statusOut == $past(statusIn))
    else $error("branch changed status flags");

  not_taken_step_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && opLegal && !condTrue
    |=> branchDone && progCounter == $past(progCounter) + CBU_PC_ONE)
    else $error("not-taken branch did not step by one in one cycle");

  not_taken_ready_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && opLegal && !condTrue
    |=> issueReady && state == CBU_IDLE && !branchTaken)
    else $error("not-taken branch blocked the next issue");

  taken_two_a: assert property (@(posedge clock) disable iff (rst)
    acceptTaken_s ##1 clkEn
    |=> branchDone && branchTaken)
    else $error("taken branch did not finish in two cycles");

  pc_hold_taken_a: assert property (@(posedge clock) disable iff (rst)
    acceptTaken_s
    |=> progCounter == $past(progCounter))
    else $error("taken branch moved pc in its first cycle");

  second_no_done_a: assert property (@(posedge clock) disable iff (rst)
    acceptTaken_s
    |=> !branchDone && !branchTaken)
    else $error("taken branch finished in one cycle");

  second_leaves_a: assert property (@(posedge clock) disable iff (rst)
    secondCycle_s
    |=> state == CBU_IDLE && issueReady && branchTaken && branchDone)
    else $error("second cycle of taken branch did not complete");

  second_ready_low_a: assert property (@(posedge clock) disable iff (rst)
    state == CBU_SECOND
    |-> !issueReady)
    else $error("ready high during second cycle of taken branch");

  taken_pulse_a: assert property (@(posedge clock) disable iff (rst)
    branchTaken
    |-> branchDone)
    else $error("taken pulse without done pulse");

  idle_quiet_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && state == CBU_IDLE && !accept
    |=> !branchDone && !branchTaken && progCounter == $past(progCounter))
    else $error("idle unit changed pc or pulsed done");

  bad_code_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && accept && !opLegal
    |=> badOpcode && branchDone && !branchTaken && progCounter == $past(progCounter) + CBU_PC_ONE)
    else $error("unknown code did not step past by one");

  // Reset and clock-enable checks
  reset_state_a: assert property (@(posedge clock)
    rst
    |=> state == CBU_IDLE && progCounter == CBU_PC_RESET && !issueReady && !branchDone)
    else $error("reset did not clear the unit");

  freeze_a: assert property (@(posedge clock) disable iff (rst)
    !rst && !clkEn
    |=> $stable(progCounter) && $stable(state) && $stable(issueReady) && $stable(branchDone))
    else $error("state moved while clock enable low");

endmodule : cbu_branch_unit

/* File: testbench/cbu_branch_unit_bench.sv */
// Self-checking bench for the conditional branch unit
`timescale 1ns/1ns
module cbu_branch_unit_bench;
  import cbu_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic issueValid = 1'b0;
  logic [3:0] issueOp = 4'h0;
  logic [CBU_OFS_W-1:0] issueOffset = 7'h00;
  logic [CBU_SREG_W-1:0] statusIn = 8'h00;
  logic issueReady;
  logic branchTaken;
  logic branchDone;
  logic badOpcode;
  logic [CBU_PC_W-1:0] progCounter;
  logic [CBU_PC_W-1:0] pcExp = 16'h0000;
  logic [CBU_SREG_W-1:0] statusOut;
  logic [CBU_SREG_W-1:0] nvBoth;
  int num_errors = 0;
  int num_checks = 0;

  // 100 ns core clock
  always #50 clock = ~clock;

  cbu_branch_unit cbu_branch_unit_inst (
    .clock(clock),
    .rst(rst),
    .clkEn(clkEn),
    .issueValid(issueValid),
    .issueOp(issueOp),
    .issueOffset(issueOffset),
    .statusIn(statusIn),
    .issueReady(issueReady),
    .progCounter(progCounter),
    .statusOut(statusOut),
    .branchTaken(branchTaken),
    .branchDone(branchDone),
    .badOpcode(badOpcode)
  );

  // Expected outcome of each branch code for a set of flags
  function automatic logic condHolds(input logic [3:0] op, input logic [7:0] f);
    case (op)
      4'h0: return f[CBU_BIT_Z];
      4'h1: return !f[CBU_BIT_Z];
      4'h2, 4'h5: return f[CBU_BIT_C];
      4'h3, 4'h4: return !f[CBU_BIT_C];
      4'h6: return f[CBU_BIT_N];
      4'h7: return !f[CBU_BIT_N];
      4'h8: return !(f[CBU_BIT_N] ^ f[CBU_BIT_V]);
      4'h9: return f[CBU_BIT_N] ^ f[CBU_BIT_V];
      4'hA: return f[CBU_BIT_H];
      4'hB: return !f[CBU_BIT_H];
      4'hC: return f[CBU_BIT_T];
      4'hD: return !f[CBU_BIT_T];
      4'hE: return f[CBU_BIT_V];
      default: return 1'b0;
    endcase
  endfunction : condHolds

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // One branch: present it, let it be accepted, then check the outcome
  task automatic doBranch(input logic [3:0] op, input logic [6:0] ofs, input logic [7:0] f);
    logic tk;
    tk = (op != 4'hF) && condHolds(op, f);
    @(posedge clock);
    issueValid <= 1'b1;
    issueOp <= op;
    issueOffset <= ofs;
    statusIn <= f;
    @(posedge clock);
    issueValid <= 1'b0;
    #1;
    check("statusOut", 16'(statusOut), 16'(f));
    check("badOpcode", 16'(badOpcode), 16'(op == 4'hF));
    if (tk) begin
      check("ready mid branch", 16'(issueReady), 16'h0000);
      check("done early", 16'(branchDone), 16'h0000);
      @(posedge clock);
      #1;
      pcExp = pcExp + {{9{ofs[6]}}, ofs} + CBU_PC_ONE;
    end else begin
      pcExp = pcExp + CBU_PC_ONE;
    end
    check("taken", 16'(branchTaken), 16'(tk));
    if (op != 4'hF) begin
      check("done", 16'(branchDone), 16'h0001);
    end
    check("progCounter", progCounter, pcExp);
    check("ready after", 16'(issueReady), 16'h0001);
  endtask : doBranch

  // Main sequence
  initial begin
    void'($urandom(78));
    nvBoth = (8'h01 << CBU_BIT_N) | (8'h01 << CBU_BIT_V);
    // Reset for 8 edges; the design still sees it high at the last one
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    #1;
    check("reset pc", progCounter, 16'h0000);
    check("reset ready", 16'(issueReady), 16'h0000);
    @(posedge clock);
    // Corners: every code, flags all clear, all set, N and V together, V alone, offset extremes
    for (int i = 0; i < 16; i++) begin
      doBranch(4'(i), 7'h3F, 8'h00);
      doBranch(4'(i), 7'h40, 8'hFF);
      doBranch(4'(i), 7'h00, nvBoth);
      doBranch(4'(i), 7'h7F, 8'h01 << CBU_BIT_V);
    end
    // Random codes, offsets and flags
    repeat (60) doBranch(4'($urandom_range(14, 0)), 7'($urandom), 8'($urandom));
    // Enable low must freeze everything, even with a taken branch waiting
    @(posedge clock);
    clkEn <= 1'b0;
    issueValid <= 1'b1;
    issueOp <= CBU_BRANCH_ON_EQUAL;
    statusIn <= 8'hFF;
    repeat (3) begin
      @(posedge clock);
      #1;
      check("frozen done", 16'(branchDone), 16'h0000);
      check("frozen pc", progCounter, pcExp);
    end
    @(posedge clock);
    issueValid <= 1'b0;
    clkEn <= 1'b1;
    // Second reset in mid-run, then one more branch
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    #1;
    check("rerun pc", progCounter, 16'h0000);
    check("rerun ready", 16'(issueReady), 16'h0000);
    @(posedge clock);
    rst <= 1'b0;
    pcExp = 16'h0000;
    @(posedge clock);
    doBranch(CBU_BRANCH_ON_OVERFLOW_SET, 7'h05, 8'hFF);
    results();
  end

  // Watchdog: far beyond the few hundred cycles the tests need
  initial begin
    #(3000 * 100);
    num_errors++;
    results();
  end
endmodule : cbu_branch_unit_bench
